/* File: pkg/brk_pkg.sv */
// Functional notes
// R1 - sequential mode: break only on a B match after an earlier A match
// R2 - sequential mode: B match before any A match gives no break
// R3 - sequential mode: A and B matching in one cycle give no break
// R4 - clearing sequential mode drops a waiting A match
// R5 - sequential mode works on either bus and with the execution count
// R6 - before-execution break saves the matching fetch address, instruction not run
// R7 - after-execution break saves the next instruction address after it completes
// R8 - address-only data break saves the address after the accessing instruction
// R9 - data-value break may land up to two instructions later, saves next address
// R10 - with trace on, branches and exceptions push source and destination
// R11 - branch source is own address; exception source is stacked return address
// R12 - software trap is traced like an exception
// R13 - four paired trace entries with one read pointer, oldest first
// R14 - source read first; pointer advances only on destination read
// R15 - turning trace off then on invalidates all entries
// R16 - address bits set in a mask are not compared
// R17 - fetch channel set to write direction never matches
// R18 - fetch break address with bit 0 set never matches
// R19 - sequential mode never breaks when channel A cannot match
// R20 - count of five on channel B suppresses four matches, breaks on fifth
// R21 - data read of any size matches long, word and byte by alignment
// R22 - data-value break needs both masked address and data to match
// R23 - destination valid flag set on push, cleared on read, enable, reset
// R24 - satisfied condition requests a break and sets that channel flags
// R25 - a push into a full queue drops the oldest entry
package brk_pkg;
    localparam logic [7:0] OFS_A_ADDR = 8'h00;
    localparam logic [7:0] OFS_A_MASK = 8'h04;
    localparam logic [7:0] OFS_A_SEL = 8'h08;
    localparam logic [7:0] OFS_B_ADDR = 8'h0C;
    localparam logic [7:0] OFS_B_MASK = 8'h10;
    localparam logic [7:0] OFS_B_SEL = 8'h14;
    localparam logic [7:0] OFS_B_DATA = 8'h18;
    localparam logic [7:0] OFS_B_DMASK = 8'h1C;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    localparam logic [7:0] OFS_COUNT = 8'h24;
    localparam logic [7:0] OFS_SRCQ = 8'h28;
    localparam logic [7:0] OFS_DSTQ = 8'h2C;
    localparam int CTL_SEQ = 0;
    localparam int CTL_TRACE = 1;
    localparam int CTL_A_POST = 2;
    localparam int CTL_B_POST = 3;
    localparam int CTL_B_CNT = 4;
    localparam int CTL_B_DATA = 5;
    localparam int CTL_FLAG_LSB = 8;
    localparam int SEL_L = 0;
    localparam int SEL_I = 1;
    localparam int SEL_FETCH = 2;
    localparam int SEL_DATA = 3;
    localparam int SEL_RD = 4;
    localparam int SEL_WR = 5;
    localparam int SEL_SZ_LSB = 6;
    localparam logic [1:0] SZ_ANY = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;
    localparam int TQ_AW = 28;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [11:0] COUNT_RST = 12'h000;
    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] data;
    } bus_cycle_s;
    typedef struct packed {
        logic valid;
        logic [31:0] pc;
        logic [31:0] next_pc;
    } retire_s;
    typedef struct packed {
        logic valid;
        logic exc;
        logic trap;
        logic [31:0] br_addr;
        logic [31:0] ret_addr;
        logic [31:0] dest;
    } branch_s;
endpackage : brk_pkg

/* File: src/user_break_unit.sv */
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module user_break_unit
    import brk_pkg::*;
#(
    parameter int TQ_DEPTH = 4,
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // cpu bus and pipeline monitor
    input wire bus_cycle_s LBUS_I,
    input wire bus_cycle_s IBUS_I,
    input wire retire_s RETIRE_I,
    input wire branch_s BRANCH_I,
    // break request to cpu
    output logic BREAK_REQ_O,
    output logic [31:0] BREAK_PC_O
);
    localparam int PW = $clog2(TQ_DEPTH);
    localparam int CW = $clog2(TQ_DEPTH + 1);
    localparam logic [CW-1:0] TQ_FULL = CW'(TQ_DEPTH);

    logic rst_q1, rst_n_r;
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_q1 <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n_r <= rst_q1;
        end
    end

    logic [31:0] a_addr_r, a_mask_r, b_addr_r, b_mask_r, b_data_r, b_dmask_r;
    logic [7:0] a_sel_r, b_sel_r;
    logic [5:0] ctl_r;
    logic [3:0] flag_r;
    logic [CNT_W-1:0] count_r, cnt_left_r;
    logic seq_armed_r, post_pend_r, data_pend_r;
    logic [31:0] post_addr_r;
    logic [TQ_AW-1:0] src_q [TQ_DEPTH];
    logic [TQ_AW-1:0] dst_q [TQ_DEPTH];
    logic [PW-1:0] wr_ptr_r, rd_ptr_r;
    logic [CW-1:0] tq_cnt_r;
    logic pready_r, pslverr_r, break_req_r;
    logic [31:0] prdata_r, break_pc_r;

    // address, direction and size match of one channel on one bus
    function automatic logic chan_hit(input bus_cycle_s c, input logic [31:0] bar,
            input logic [31:0] bam, input logic [7:0] sel, input logic on_bus);
        logic [31:0] cmp;
        logic kind_ok, dir_ok, size_ok;
        cmp = ~bam;
        // R21 size alignment
        if (!c.fetch && c.size == SZ_LONG) cmp[1:0] = 2'h0;
        if (!c.fetch && c.size == SZ_WORD) cmp[0] = 1'b0;
        // R18 odd fetch address
        kind_ok = c.fetch ? (sel[SEL_FETCH] & ~bar[0]) : sel[SEL_DATA];
        // R17 fetch is a read
        dir_ok = (c.fetch || !c.write) ? sel[SEL_RD] : sel[SEL_WR];
        size_ok = c.fetch || sel[SEL_SZ_LSB +: 2] == SZ_ANY
            || sel[SEL_SZ_LSB +: 2] == c.size;
        // R16 masked compare
        chan_hit = c.valid & on_bus & kind_ok & dir_ok & size_ok
            & (((c.addr ^ bar) & cmp) == 32'h0);
    endfunction : chan_hit

    // R22 data value compare
    function automatic logic data_hit(input bus_cycle_s c, input logic [31:0] bdr,
            input logic [31:0] bdm, input logic en);
        logic [31:0] m;
        m = (c.size == SZ_LONG) ? ~bdm : {16'h0, ~bdm[15:0]};
        data_hit = !en || c.fetch || (((c.data ^ bdr) & m) == 32'h0);
    endfunction : data_hit

    logic hit_al, hit_ai, hit_bl, hit_bi, a_hit, b_hit, b_qual, b_cnt_ok;
    logic a_go, b_go;
    bus_cycle_s a_cyc, b_cyc;
    assign hit_al = chan_hit(LBUS_I, a_addr_r, a_mask_r, a_sel_r, a_sel_r[SEL_L]);
    assign hit_ai = chan_hit(IBUS_I, a_addr_r, a_mask_r, a_sel_r, a_sel_r[SEL_I]);
    assign hit_bl = chan_hit(LBUS_I, b_addr_r, b_mask_r, b_sel_r, b_sel_r[SEL_L])
        & data_hit(LBUS_I, b_data_r, b_dmask_r, ctl_r[CTL_B_DATA]);
    assign hit_bi = chan_hit(IBUS_I, b_addr_r, b_mask_r, b_sel_r, b_sel_r[SEL_I])
        & data_hit(IBUS_I, b_data_r, b_dmask_r, ctl_r[CTL_B_DATA]);
    assign a_hit = hit_al | hit_ai;
    assign b_hit = hit_bl | hit_bi;
    assign a_cyc = hit_al ? LBUS_I : IBUS_I;
    assign b_cyc = hit_bl ? LBUS_I : IBUS_I;
    // R1 R2 R3 R19 sequential qualification
    assign b_qual = b_hit & (~ctl_r[CTL_SEQ] | (seq_armed_r & ~a_hit));
    // R20 execution count
    assign b_cnt_ok = ~ctl_r[CTL_B_CNT] | (cnt_left_r <= CNT_W'(1));
    assign a_go = a_hit & ~ctl_r[CTL_SEQ];
    assign b_go = b_qual & b_cnt_ok;

    // apb decode
    logic acc, wr_en, rd_en, mapped;
    logic [31:0] rd_mux;
    assign acc = PSEL_I & PENABLE_I & pready_r;
    assign wr_en = acc & PWRITE_I & mapped;
    assign rd_en = acc & ~PWRITE_I & mapped;
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        unique case (PADDR_I)
            OFS_A_ADDR: rd_mux = a_addr_r;
            OFS_A_MASK: rd_mux = a_mask_r;
            OFS_A_SEL: rd_mux = {24'h0, a_sel_r};
            OFS_B_ADDR: rd_mux = b_addr_r;
            OFS_B_MASK: rd_mux = b_mask_r;
            OFS_B_SEL: rd_mux = {24'h0, b_sel_r};
            OFS_B_DATA: rd_mux = b_data_r;
            OFS_B_DMASK: rd_mux = b_dmask_r;
            OFS_CTRL: rd_mux = {20'h0, flag_r, 2'h0, ctl_r};
            OFS_COUNT: rd_mux = {{(32-CNT_W){1'b0}}, count_r};
            OFS_SRCQ: rd_mux = {4'h0, src_q[rd_ptr_r]};
            // R23 valid flag in top bit
            OFS_DSTQ: rd_mux = {tq_cnt_r != '0, 3'h0, dst_q[rd_ptr_r]};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= REG_RST;
        end else begin
            pready_r <= PSEL_I & PENABLE_I & ~pready_r;
            pslverr_r <= PSEL_I & PENABLE_I & ~pready_r & ~mapped;
            prdata_r <= (PSEL_I & PENABLE_I & ~pready_r & ~PWRITE_I) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            a_addr_r <= REG_RST;
            a_mask_r <= REG_RST;
            b_addr_r <= REG_RST;
            b_mask_r <= REG_RST;
            b_data_r <= REG_RST;
            b_dmask_r <= REG_RST;
            a_sel_r <= 8'h00;
            b_sel_r <= 8'h00;
            ctl_r <= 6'h00;
            count_r <= COUNT_RST;
        end else if (wr_en) begin
            if (PADDR_I == OFS_A_ADDR) a_addr_r <= PWDATA_I;
            if (PADDR_I == OFS_A_MASK) a_mask_r <= PWDATA_I;
            if (PADDR_I == OFS_A_SEL) a_sel_r <= PWDATA_I[7:0];
            if (PADDR_I == OFS_B_ADDR) b_addr_r <= PWDATA_I;
            if (PADDR_I == OFS_B_MASK) b_mask_r <= PWDATA_I;
            if (PADDR_I == OFS_B_SEL) b_sel_r <= PWDATA_I[7:0];
            if (PADDR_I == OFS_B_DATA) b_data_r <= PWDATA_I;
            if (PADDR_I == OFS_B_DMASK) b_dmask_r <= PWDATA_I;
            if (PADDR_I == OFS_CTRL) ctl_r <= PWDATA_I[5:0];
            if (PADDR_I == OFS_COUNT) count_r <= PWDATA_I[CNT_W-1:0];
        end
    end

    // R24 match flags, hardware set beats a software clear
    logic wr_ctl;
    assign wr_ctl = wr_en & (PADDR_I == OFS_CTRL);
    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flag_r <= 4'h0;
        end else begin
            flag_r <= (wr_ctl ? (flag_r & PWDATA_I[CTL_FLAG_LSB +: 4]) : flag_r)
                | {b_go & hit_bi, b_go & hit_bl, a_go & hit_ai, a_go & hit_al};
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            seq_armed_r <= 1'b0;
        // R4 leaving sequential mode drops the arm
        end else if (!ctl_r[CTL_SEQ]) begin
            seq_armed_r <= 1'b0;
        end else if (a_hit) begin
            seq_armed_r <= 1'b1;
        end else if (b_go) begin
            seq_armed_r <= 1'b0;
        end
    end

    // R20 R5 remaining matches before the channel B break
    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_left_r <= COUNT_RST;
        end else if (wr_en && PADDR_I == OFS_COUNT) begin
            cnt_left_r <= PWDATA_I[CNT_W-1:0];
        end else if (b_qual && ctl_r[CTL_B_CNT]) begin
            cnt_left_r <= b_cnt_ok ? count_r : cnt_left_r - CNT_W'(1);
        end
    end

    // break timing by kind
    logic a_pre, b_pre, a_post, b_post, a_dat, b_dat, pre_fire, post_fire, data_fire;
    logic [31:0] pre_pc;
    assign a_pre = a_go & a_cyc.fetch & ~ctl_r[CTL_A_POST];
    assign b_pre = b_go & b_cyc.fetch & ~ctl_r[CTL_B_POST];
    assign a_post = a_go & a_cyc.fetch & ctl_r[CTL_A_POST];
    assign b_post = b_go & b_cyc.fetch & ctl_r[CTL_B_POST];
    assign a_dat = a_go & ~a_cyc.fetch;
    assign b_dat = b_go & ~b_cyc.fetch;
    assign pre_fire = a_pre | b_pre;
    assign pre_pc = a_pre ? a_cyc.addr : b_cyc.addr;
    assign post_fire = post_pend_r & RETIRE_I.valid & (RETIRE_I.pc == post_addr_r);
    assign data_fire = data_pend_r & RETIRE_I.valid;

    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            post_pend_r <= 1'b0;
            post_addr_r <= REG_RST;
            data_pend_r <= 1'b0;
        end else begin
            if (a_post | b_post) begin
                post_pend_r <= 1'b1;
                post_addr_r <= a_post ? a_cyc.addr : b_cyc.addr;
            end else if (post_fire | pre_fire) begin
                post_pend_r <= 1'b0;
            end
            if (a_dat | b_dat) begin
                data_pend_r <= 1'b1;
            end else if (data_fire | pre_fire | post_fire) begin
                data_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            break_req_r <= 1'b0;
            break_pc_r <= REG_RST;
        end else begin
            break_req_r <= pre_fire | post_fire | data_fire;
            // R6 fetch address, instruction not run
            if (pre_fire) begin
                break_pc_r <= pre_pc;
            // R7 R8 R9 address of the next instruction
            end else if (post_fire | data_fire) begin
                break_pc_r <= RETIRE_I.next_pc;
            end
        end
    end

    // trace queue
    logic push, pop, tq_full, trace_clr;
    logic [31:0] push_src;
    assign trace_clr = wr_ctl & PWDATA_I[CTL_TRACE] & ~ctl_r[CTL_TRACE];
    // R10 record while enabled
    assign push = BRANCH_I.valid & ctl_r[CTL_TRACE];
    // R14 shift only on the destination read
    assign pop = rd_en & (PADDR_I == OFS_DSTQ) & (tq_cnt_r != '0);
    assign tq_full = tq_cnt_r == TQ_FULL;
    // R11 R12 exception and trap use the return address
    assign push_src = (BRANCH_I.exc | BRANCH_I.trap) ? BRANCH_I.ret_addr
        : BRANCH_I.br_addr;

    always_ff @(posedge MCLK_I) begin
        if (push) begin
            src_q[wr_ptr_r] <= push_src[TQ_AW-1:0];
            dst_q[wr_ptr_r] <= BRANCH_I.dest[TQ_AW-1:0];
        end
    end

    // R13 R25 R15 R23 shared read pointer, overwrite oldest, clear on enable
    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            tq_cnt_r <= '0;
        end else if (trace_clr) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            tq_cnt_r <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + PW'(1);
            if (pop | (push & tq_full)) rd_ptr_r <= rd_ptr_r + PW'(1);
            if (push & ~pop & ~tq_full) begin
                tq_cnt_r <= tq_cnt_r + CW'(1);
            end else if (pop & ~push) begin
                tq_cnt_r <= tq_cnt_r - CW'(1);
            end
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign BREAK_REQ_O = break_req_r;
    assign BREAK_PC_O = break_pc_r;

    a_seq_needs_arm: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R2
        ctl_r[CTL_SEQ] && !seq_armed_r |-> !b_go) else $error("early B broke");
    a_seq_same_cycle: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R3
        ctl_r[CTL_SEQ] && a_hit && b_hit |-> !b_go) else $error("A and B together broke");
    a_seq_drop_arm: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R4
        !ctl_r[CTL_SEQ] |=> !seq_armed_r || $past(a_hit)) else $error("arm kept");
    a_pre_exec_pc: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R6
        pre_fire |=> BREAK_REQ_O && BREAK_PC_O == $past(pre_pc)) else $error("pre pc");
    a_post_exec_pc: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R7
        post_fire && !pre_fire |=> BREAK_REQ_O && BREAK_PC_O == $past(RETIRE_I.next_pc))
        else $error("post pc");
    a_odd_fetch_addr: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R18
        LBUS_I.fetch && b_addr_r[0] |-> !hit_bl) else $error("odd fetch");
    a_count_hold: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R20
        b_qual && ctl_r[CTL_B_CNT] && cnt_left_r > CNT_W'(1) |-> !b_go
        ##1 cnt_left_r == $past(cnt_left_r) - CNT_W'(1) || $past(wr_en))
        else $error("count early");
    a_enable_clears: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R15
        trace_clr |=> tq_cnt_r == '0 ##1 !rd_mux[31] || PADDR_I != OFS_DSTQ
        || tq_cnt_r != '0) else $error("stale entry");
    a_queue_bound: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R25
        tq_cnt_r <= TQ_FULL) else $error("queue over depth");
    a_flag_on_break: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R24
        b_go && hit_bl |=> flag_r[2]) else $error("no B flag");
    a_data_break_pc: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R8
        data_fire && !pre_fire |=> BREAK_REQ_O && BREAK_PC_O == $past(RETIRE_I.next_pc))
        else $error("data pc");
    a_push_sets_valid: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R23
        push && !trace_clr |=> tq_cnt_r != '0) else $error("valid not set");
    a_trace_off_idle: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R10
        !ctl_r[CTL_TRACE] && !pop && !trace_clr |=> $stable(tq_cnt_r))
        else $error("push while off");
    a_src_read_keeps: assert property (@(posedge MCLK_I) disable iff (!rst_n_r) // R14
        rd_en && PADDR_I == OFS_SRCQ && !push |=> $stable(rd_ptr_r))
        else $error("source read moved pointer");
    c_post_break: cover property (@(posedge MCLK_I) disable iff (!rst_n_r)
        post_fire ##1 BREAK_REQ_O);
    c_seq_break: cover property (@(posedge MCLK_I) disable iff (!rst_n_r)
        ctl_r[CTL_SEQ] && b_go ##1 BREAK_REQ_O);
    c_queue_wrap: cover property (@(posedge MCLK_I) disable iff (!rst_n_r)
        push && tq_full);
    c_count_break: cover property (@(posedge MCLK_I) disable iff (!rst_n_r)
        ctl_r[CTL_B_CNT] && b_go);
endmodule : user_break_unit

/* File: test/cpu_model.sv */
`timescale 1ns/1ns
module cpu_model
    import brk_pkg::*;
(
    // clock
    input wire logic clk_i,
    // pipeline side
    output bus_cycle_s lbus_o,
    output bus_cycle_s ibus_o,
    output retire_s retire_o,
    output branch_s branch_o
);
    initial begin
        lbus_o = '0;
        ibus_o = '0;
        retire_o = '0;
        branch_o = '0;
    end

    // one bus cycle; released lines carry inverted values so stale ones never match
    task automatic bus_op(input logic on_i, input logic fe, input logic w, input logic [1:0] sz,
            input logic [31:0] a, input logic [31:0] d);
        bus_cycle_s c;
        c = '{1'b1, fe, w, sz, a, d};
        if (on_i) ibus_o <= c; else lbus_o <= c;
        @(posedge clk_i);
        c = '{1'b0, 1'b0, 1'b0, ~sz, ~a, ~d};
        if (on_i) ibus_o <= c; else lbus_o <= c;
    endtask : bus_op

    task automatic retire_op(input logic [31:0] pc, input logic [31:0] npc);
        retire_o <= '{1'b1, pc, npc};
        @(posedge clk_i);
        retire_o <= '{1'b0, ~pc, ~npc};
    endtask : retire_op

    // branch, exception or trap with own and return address
    task automatic branch_op(input logic ex, input logic tr, input logic [31:0] ba,
            input logic [31:0] ra, input logic [31:0] ds);
        branch_o <= '{1'b1, ex, tr, ba, ra, ds};
        @(posedge clk_i);
        branch_o <= '{1'b0, 1'b0, 1'b0, ~ba, ~ra, ~ds};
    endtask : branch_op
endmodule : cpu_model

/* File: test/test_user_break_sequencing_and_pc_trace.sv */
`timescale 1ns/1ns
module test_user_break_sequencing_and_pc_trace
    import brk_pkg::*;
;
    logic clk;
    logic rstn;
    logic psel, penable, pwrite, pready, pslverr, brk, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, brk_pc, rd, x, a0, a1;
    bus_cycle_s lbus, ibus;
    retire_s ret;
    branch_s br;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    integer seed = 32'h3016;
    logic [31:0] src_q[5];
    logic [31:0] dst_q[5];
    logic [1:0] sz_t[5] = '{2'h3, 2'h2, 2'h1, 2'h2, 2'h1};
    logic [31:0] ad_t[5] = '{32'h123454, 32'h123456, 32'h123456, 32'h123454, 32'h123457};

    user_break_unit user_break_unit_i (.MCLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LBUS_I(lbus),
        .IBUS_I(ibus), .RETIRE_I(ret), .BRANCH_I(br), .BREAK_REQ_O(brk), .BREAK_PC_O(brk_pc));
    cpu_model cpu_model_i (.clk_i(clk), .lbus_o(lbus), .ibus_o(ibus), .retire_o(ret),
        .branch_o(br));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(n, 32'h1, "apb wait");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
            input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e & m, msg);
    endtask : rdc

    task automatic setup(input logic [31:0] v[6], input logic [31:0] c);
        wr(OFS_CTRL, 32'h0);
        for (int i = 0; i < 6; i++) wr(8'(4 * i), v[i]);
        wr(OFS_CTRL, c);
    endtask : setup

    task automatic f(input logic on_i, input logic [31:0] a);
        cpu_model_i.bus_op(on_i, 1'b1, 1'b0, 2'h2, a, 32'h0);
    endtask : f

    task automatic watch(input logic e, input logic [31:0] pc, input string msg);
        logic hit;
        logic [31:0] got;
        hit = 1'b0;
        got = 32'h0;
        repeat (4) begin
            @(posedge clk);
            if (brk === 1'b1) begin
                hit = 1'b1;
                got = brk_pc;
            end
        end
        chk({31'h0, hit}, {31'h0, e}, msg);
        if (e) chk(got, pc, msg);
    endtask : watch

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(OFS_CTRL, REG_RST, '1, "ctrl reset");
        rdc(OFS_COUNT, {20'h0, COUNT_RST}, '1, "count reset");
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        x = $random(seed);
        wr(OFS_B_DATA, x);
        rdc(OFS_B_DATA, x, '1, "data reg");
        $display("test registers finished");
        setup('{0, 0, 0, 32'h8010, 32'h6, 32'h15}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            f(1'b0, 32'h8010 + 2 * i);
            watch(i < 4, 32'h8010 + 2 * i, "masked fetch");
        end
        rdc(OFS_CTRL, 32'h400, 32'hF00, "b flag");
        setup('{32'h27128, 0, 32'h25, 32'h31415, 32'h1, 32'h15}, 32'h0);
        f(1'b0, 32'h27128);
        watch(1'b0, 0, "write fetch");
        f(1'b0, 32'h31414);
        watch(1'b0, 0, "odd address");
        $display("test fetch finished");
        setup('{32'h37226, 0, 32'h15, 32'h3722E, 0, 32'h15}, 32'h1);
        f(1'b0, 32'h3722E);
        watch(1'b0, 0, "b first");
        f(1'b0, 32'h37226);
        watch(1'b0, 0, "a arms");
        f(1'b0, 32'h3722E);
        watch(1'b1, 32'h3722E, "a then b");
        f(1'b0, 32'h37226);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h1);
        f(1'b0, 32'h3722E);
        watch(1'b0, 0, "seq cleared");
        wr(OFS_B_ADDR, 32'h37226);
        f(1'b0, 32'h37226);
        @(posedge clk);
        f(1'b0, 32'h37226);
        watch(1'b0, 0, "same cycle");
        setup('{32'h37226, 0, 32'h25, 32'h3722E, 0, 32'h15}, 32'h1);
        f(1'b0, 32'h37226);
        @(posedge clk);
        f(1'b0, 32'h3722E);
        watch(1'b0, 0, "a never");
        $display("test sequential finished");
        setup('{0, 0, 0, 32'h1000, 0, 32'hD5}, 32'h10);
        wr(OFS_COUNT, 32'h5);
        for (int i = 0; i < 5; i++) begin
            f(1'b0, 32'h1000);
            watch(i == 4, 32'h1000, "count five");
        end
        setup('{32'h500, 0, 32'hD6, 32'h1000, 0, 32'hD6}, 32'h11);
        wr(OFS_COUNT, 32'h1);
        f(1'b1, 32'h500);
        @(posedge clk);
        f(1'b1, 32'h1000);
        watch(1'b1, 32'h1000, "seq count i bus");
        $display("test count finished");
        setup('{32'h404, 0, 32'h15, 32'h408, 0, 32'h15}, 32'hC);
        f(1'b0, 32'h404);
        watch(1'b0, 0, "post before retire");
        cpu_model_i.retire_op(32'h404, 32'h406);
        watch(1'b1, 32'h406, "post break");
        f(1'b0, 32'h408);
        cpu_model_i.retire_op(32'h408, 32'h40A);
        watch(1'b1, 32'h40A, "b post break");
        setup('{32'h123456, 0, 32'h19, 0, 0, 0}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            cpu_model_i.bus_op(1'b0, 1'b0, 1'b0, sz_t[i], ad_t[i], $random(seed));
            cpu_model_i.retire_op(32'h200 + 2 * i, 32'h202 + 2 * i);
            watch(i < 3, 32'h202 + 2 * i, "read size");
        end
        setup('{0, 0, 0, 32'hABCDE, 32'hFF, 32'hA9}, 32'h20);
        wr(OFS_B_DATA, 32'hA512);
        wr(OFS_B_DMASK, 32'h0);
        cpu_model_i.bus_op(1'b0, 1'b0, 1'b1, 2'h2, 32'hABC10, 32'hA512);
        cpu_model_i.retire_op(32'h300, 32'h302);
        watch(1'b1, 32'h302, "data hit");
        x = $random(seed) | 32'h1;
        cpu_model_i.bus_op(1'b0, 1'b0, 1'b1, 2'h2, 32'hABC10, {16'h0, 16'hA512 ^ x[15:0]});
        cpu_model_i.retire_op(32'h304, 32'h306);
        watch(1'b0, 0, "data miss");
        cpu_model_i.bus_op(1'b0, 1'b0, 1'b1, 2'h2, 32'hABD10, 32'hA512);
        cpu_model_i.retire_op(32'h308, 32'h30A);
        watch(1'b0, 0, "address miss");
        $display("test data finished");
        wr(OFS_CTRL, 32'h2);
        for (int i = 0; i < 5; i++) begin
            a0 = $random(seed);
            a1 = $random(seed);
            dst_q[i] = $random(seed);
            src_q[i] = (i % 3 == 0) ? a0 : a1;
            cpu_model_i.branch_op(i % 3 == 1, i % 3 == 2, a0, a1, dst_q[i]);
            @(posedge clk);
        end
        for (int i = 1; i < 5; i++) begin
            rdc(OFS_SRCQ, {4'h0, src_q[i][27:0]}, '1, "source");
            rdc(OFS_SRCQ, {4'h0, src_q[i][27:0]}, '1, "source again");
            rdc(OFS_DSTQ, {4'h8, dst_q[i][27:0]}, '1, "dest");
        end
        rdc(OFS_DSTQ, 32'h0, 32'h8000_0000, "empty");
        cpu_model_i.branch_op(1'b0, 1'b0, a0, a1, a0);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h2);
        rdc(OFS_DSTQ, 32'h0, 32'h8000_0000, "re-enabled");
        $display("test trace finished");
        report_and_stop;
    end
endmodule : test_user_break_sequencing_and_pc_trace
